/* core/bsms_pkg.sv */
// Shared types and constants for the buck start-up and mode sequencer.
// Assumes a single 250 MHz clock and pins already digitised by comparators.
package bsms_pkg;
    // Clock rate
    localparam int CLK_MHZ = 250;
    // Times as printed, each with its derived cycle count
    localparam int START_DELAY_US = 1000;
    localparam int START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
    localparam int SS_RAMP_US = 1500;
    localparam int SS_RAMP_CYC = SS_RAMP_US * CLK_MHZ;
    localparam int RISE_DELAY_US = 3000;
    localparam int RISE_DELAY_CYC = RISE_DELAY_US * CLK_MHZ;
    localparam int DEGLITCH_US = 20;
    localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
    localparam int SYNC_IDLE_NS = 100;
    localparam int SYNC_IDLE_CYC = (SYNC_IDLE_NS * CLK_MHZ) / 1000;
    // Dither pattern: 255 steps repeating at 0.98 Hz
    localparam longint PSS_CENTIHZ = 98;
    localparam longint LFSR_STEPS = 255;
    localparam int SPREAD_STEP_CYC =
        int'((longint'(CLK_MHZ) * 100000000) / (PSS_CENTIHZ * LFSR_STEPS));
    localparam int SPREAD_TENTH_PCT = 30;
    localparam logic [7:0] LFSR_SEED = 8'h01;
    // Frequency figures in kHz
    localparam logic [11:0] FREQ_LOW_KHZ = 12'd400;
    localparam logic [11:0] FREQ_HIGH_KHZ = 12'd2100;
    localparam logic [11:0] FREQ_ADJ_MIN_KHZ = 12'd250;
    localparam logic [11:0] FREQ_ADJ_MAX_KHZ = 12'd2200;
    localparam int RT_SCALE = 15770;
    // Counter and reference widths
    localparam int CNT_W = 20;
    localparam int REF_W = 10;
    localparam logic [REF_W-1:0] REF_FULL = 10'h3ff;

    typedef enum logic [2:0] {PS_OFF, PS_STANDBY, PS_DELAY, PS_RAMP, PS_RUN} bsmsPower_e;
    typedef enum logic [1:0] {LV_3V3, LV_5V, LV_EXT_DIV} bsmsLevel_e;
    typedef enum logic [1:0] {FQ_400K, FQ_2100K, FQ_ADJ, FQ_NONE} bsmsFreq_e;

    // Enable comparator outputs, lowest threshold first
    typedef struct packed {
        logic aboveStandby;
        logic aboveStop;
        logic aboveActive;
    } bsmsEnable_s;

    // Digitised strap pins
    typedef struct packed {
        logic levelHigh;
        logic levelLow;
        logic freqHigh;
        logic freqLow;
        logic freqFloat;
        logic [7:0] rtKohm;
    } bsmsStraps_s;

    // Registered status toward the analog core
    typedef struct packed {
        bsmsPower_e state;
        logic vccOn;
        logic switchEn;
        logic forcedFixed;
        logic pulseSkip;
        logic syncLocked;
        bsmsLevel_e level;
        logic internalDividerOn;
        bsmsFreq_e freq;
        logic [11:0] freqKhz;
        logic [REF_W-1:0] refCode;
        logic signed [7:0] ditherTenthPct;
    } bsmsStatus_s;
endpackage : bsms_pkg

/* core/bsms_sync_detect.sv */
// Classifies the clock-or-mode pin as steady high, steady low or toggling.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module bsms_sync_detect
    import bsms_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstSyncN,
    input wire logic ce,
    // Pin
    input wire logic modePin,
    // Classification
    output logic syncClockValid,
    output logic modeHigh,
    output logic modeLow
);
    logic prevPin;
    logic [5:0] idleCnt;
    logic edgeSeen;
    logic idleDone;

    // Any edge restarts the idle count
    assign edgeSeen = modePin ^ prevPin;
    assign idleDone = idleCnt == 6'(SYNC_IDLE_CYC);

    // Idle counter saturates at the fallback time
    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            prevPin <= 1'b0;
            idleCnt <= 6'(SYNC_IDLE_CYC);
        end else if (ce) begin
            prevPin <= modePin;
            idleCnt <= edgeSeen ? 6'h00 : (idleDone ? idleCnt : idleCnt + 6'h01);
        end
    end

    // Steady level only once the pin has been quiet long enough
    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            syncClockValid <= 1'b0;
            modeHigh <= 1'b0;
            modeLow <= 1'b1;
        end else if (ce) begin
            syncClockValid <= !idleDone;
            modeHigh <= idleDone && prevPin;
            modeLow <= idleDone && !prevPin;
        end
    end

    property p_sync_fallback;
        @(posedge clock) disable iff (!rstSyncN || !ce)
        (idleDone && ce) |=> (!syncClockValid && (modeHigh != modeLow));
    endproperty
    a_sync_fallback: assert property (p_sync_fallback) else $error("sync fallback missed");
endmodule : bsms_sync_detect
`default_nettype wire

/* core/bsms_sequencer.sv */
// Enable sequencer, strap capture, mode choice and reset flag for a buck.
// Assumes all pins are comparator outputs synchronous to the 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module bsms_sequencer
    import bsms_pkg::*;
#(
    parameter int unsigned START_DELAY = START_DELAY_CYC,
    parameter int unsigned RAMP_TIME = SS_RAMP_CYC,
    parameter int unsigned RISE_DELAY = RISE_DELAY_CYC,
    parameter int unsigned DEGLITCH = DEGLITCH_CYC,
    parameter int unsigned SPREAD_STEP = SPREAD_STEP_CYC
) (
    // Clock, power-on reset and clock enable
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    // Enable comparators and straps
    input wire bsmsEnable_s enable,
    input wire bsmsStraps_s straps,
    input wire logic modePin,
    input wire logic spreadFitted,
    // Analog core feedback
    input wire logic loadLight,
    input wire logic fbInRegulation,
    input wire logic currentLimit,
    input wire logic thermalShutdown,
    // Open-drain reset flag
    input wire logic resetFlagIn,
    output logic resetFlagOut,
    output logic resetFlagOe,
    // Status toward the core
    output var bsmsStatus_s status
);
    logic rstMeta;
    logic rstSyncN;
    bsmsPower_e state;
    bsmsPower_e next_state;
    logic [CNT_W-1:0] cnt;
    logic strapsTaken;
    bsmsLevel_e levelSel;
    bsmsFreq_e freqSel;
    logic [11:0] adjKhz;
    logic [CNT_W-1:0] glitchCnt;
    logic [CNT_W-1:0] releaseCnt;
    logic tripped;
    logic flagHigh;
    logic [7:0] lfsr;
    logic [CNT_W-1:0] spreadCnt;
    logic syncClockValid;
    logic modeHigh;
    logic modeLow;
    logic delayDone;
    logic rampDone;
    logic takeStraps;
    logic faultNow;
    logic glitchDone;
    logic releaseOk;
    logic switchEn;
    logic forcedReq;
    logic forcedNow;
    logic spreadTick;
    bsmsStatus_s next_status;

    // Level strap decode
    function automatic bsmsLevel_e decodeLevel(input logic hi, input logic lo);
        decodeLevel = hi ? LV_5V : (lo ? LV_3V3 : LV_EXT_DIV);
    endfunction : decodeLevel

    // Frequency strap decode; float wins since it means no switching
    function automatic bsmsFreq_e decodeFreq(input logic hi, input logic lo, input logic fl);
        decodeFreq = fl ? FQ_NONE : (hi ? FQ_400K : (lo ? FQ_2100K : FQ_ADJ));
    endfunction : decodeFreq

    // Resistor to kHz, clamped to the usable window
    function automatic logic [11:0] rtToKhz(input logic [7:0] kohm);
        int f;
        f = (kohm == 8'h00) ? RT_SCALE : RT_SCALE / int'(kohm);
        if (f > int'(FREQ_ADJ_MAX_KHZ)) begin
            f = int'(FREQ_ADJ_MAX_KHZ);
        end
        if (f < int'(FREQ_ADJ_MIN_KHZ)) begin
            f = int'(FREQ_ADJ_MIN_KHZ);
        end
        rtToKhz = 12'(f);
    endfunction : rtToKhz

    // Power-on reset release through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    bsms_sync_detect u_sync (
        .clock(clock),
        .rstSyncN(rstSyncN),
        .ce(ce),
        .modePin(modePin),
        .syncClockValid(syncClockValid),
        .modeHigh(modeHigh),
        .modeLow(modeLow)
    );

    // Start-up timers against the cycle counter
    assign delayDone = cnt == CNT_W'(START_DELAY - 1);
    assign rampDone = cnt == CNT_W'(RAMP_TIME - 1);

    // Enable state machine
    always_comb begin
        next_state = state;
        case (state)
            PS_OFF: begin
                if (enable.aboveStandby) begin
                    next_state = PS_STANDBY;
                end
            end
            PS_STANDBY: begin
                if (!enable.aboveStandby) begin
                    next_state = PS_OFF;
                end else if (enable.aboveActive) begin
                    next_state = PS_DELAY;
                end
            end
            PS_DELAY, PS_RAMP, PS_RUN: begin
                if (!enable.aboveStandby) begin
                    next_state = PS_OFF;
                end else if (!enable.aboveStop) begin
                    next_state = PS_STANDBY;
                end else if (state == PS_DELAY && delayDone) begin
                    next_state = PS_RAMP;
                end else if (state == PS_RAMP && rampDone) begin
                    next_state = PS_RUN;
                end
            end
            default: begin
                next_state = PS_OFF;
            end
        endcase
    end

    // State and phase counter; counter restarts on every state change
    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state <= PS_OFF;
            cnt <= '0;
        end else if (ce) begin
            state <= next_state;
            cnt <= (next_state != state) ? '0 : cnt + CNT_W'(1);
        end
    end

    // Straps are taken on the first entry into start-up only
    assign takeStraps = !strapsTaken && state == PS_STANDBY && next_state == PS_DELAY;

    // Strap registers survive enable cycling; only power-on clears them
    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            strapsTaken <= 1'b0;
            levelSel <= LV_3V3;
            freqSel <= FQ_NONE;
            adjKhz <= FREQ_ADJ_MIN_KHZ;
        end else if (ce && takeStraps) begin
            strapsTaken <= 1'b1;
            levelSel <= decodeLevel(straps.levelHigh, straps.levelLow);
            freqSel <= decodeFreq(straps.freqHigh, straps.freqLow, straps.freqFloat);
            adjKhz <= rtToKhz(straps.rtKohm);
        end
    end

    // Flag conditions: faults pull at once, feedback only after deglitch
    assign faultNow = currentLimit || thermalShutdown;
    assign glitchDone = glitchCnt == CNT_W'(DEGLITCH - 1);
    assign releaseOk = state == PS_RUN && !tripped && !faultNow;

    // Deglitch and release counters
    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            glitchCnt <= '0;
            tripped <= 1'b1;
            releaseCnt <= '0;
            flagHigh <= 1'b0;
        end else if (ce) begin
            glitchCnt <= fbInRegulation ? '0 : (glitchDone ? glitchCnt : glitchCnt + CNT_W'(1));
            tripped <= faultNow || (!fbInRegulation && (glitchDone || tripped));
            releaseCnt <= !releaseOk ? '0 :
                (flagHigh ? releaseCnt : releaseCnt + CNT_W'(1));
            flagHigh <= releaseOk && (flagHigh || releaseCnt == CNT_W'(RISE_DELAY - 1));
        end
    end

    // Open drain: only ever pull low, the board pull-up makes the high
    assign resetFlagOut = 1'b0;
    assign resetFlagOe = !flagHigh;

    // Dither pattern advances at a fixed step so the full cycle is 0.98 Hz
    assign spreadTick = spreadCnt == CNT_W'(SPREAD_STEP - 1);

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            lfsr <= LFSR_SEED;
            spreadCnt <= '0;
        end else if (ce && spreadFitted) begin
            spreadCnt <= spreadTick ? '0 : spreadCnt + CNT_W'(1);
            if (spreadTick) begin
                lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            end
        end
    end

    // Mode choice; forced mode is held off until start-up completes
    assign switchEn = (state == PS_RAMP || state == PS_RUN) && freqSel != FQ_NONE;
    assign forcedReq = modeHigh || syncClockValid;
    assign forcedNow = forcedReq && state == PS_RUN && switchEn;

    // Status assembly, registered toward the core
    always_comb begin
        next_status.state = state;
        next_status.vccOn = state != PS_OFF;
        next_status.switchEn = switchEn;
        next_status.forcedFixed = forcedNow;
        next_status.pulseSkip = switchEn && !forcedNow && loadLight;
        next_status.syncLocked = forcedNow && syncClockValid;
        next_status.level = levelSel;
        next_status.internalDividerOn = levelSel != LV_EXT_DIV;
        next_status.freq = freqSel;
        next_status.freqKhz = (freqSel == FQ_400K) ? FREQ_LOW_KHZ :
            (freqSel == FQ_2100K) ? FREQ_HIGH_KHZ :
            (freqSel == FQ_ADJ) ? adjKhz : 12'h000;
        next_status.refCode = (state == PS_RUN) ? REF_FULL :
            (state == PS_RAMP) ? REF_W'((64'(cnt) << REF_W) / 64'(RAMP_TIME)) : '0;
        next_status.ditherTenthPct = spreadFitted ?
            8'(int'(lfsr) % (2 * SPREAD_TENTH_PCT + 1) - SPREAD_TENTH_PCT) : 8'sh00;
    end

    always_ff @(posedge clock or negedge rstSyncN) begin
        if (!rstSyncN) begin
            status <= '{state: PS_OFF, level: LV_3V3, freq: FQ_NONE, default: '0};
        end else if (ce) begin
            status <= next_status;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rstSyncN || !ce);

    sequence s_delayEnd;
        state == PS_DELAY && delayDone && enable.aboveStop && enable.aboveStandby;
    endsequence
    sequence s_rampStart;
        state == PS_RAMP && cnt == '0;
    endsequence

    property p_start_delay;
        s_delayEnd |=> s_rampStart;
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("ramp start missed");
    property p_shutdown;
        !enable.aboveStandby |=> state == PS_OFF ##1 status.state == PS_OFF;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("no shutdown");
    property p_standby_start;
        (state == PS_STANDBY && enable.aboveStandby && enable.aboveActive) |=> state == PS_DELAY;
    endproperty
    a_standby_start: assert property (p_standby_start) else $error("start refused");
    property p_enable_low_flag;
        (state != PS_RUN) |=> resetFlagOe;
    endproperty
    a_enable_low_flag: assert property (p_enable_low_flag) else $error("flag not low");
    property p_forced_after_ramp;
        status.forcedFixed |-> status.state == PS_RUN;
    endproperty
    a_forced_after_ramp: assert property (p_forced_after_ramp) else $error("early forced");
    // A quiet low mode pin must hand control back to the load-adaptive choice
    property p_low_adaptive;
        modeLow |=> !status.forcedFixed;
    endproperty
    a_low_adaptive: assert property (p_low_adaptive) else $error("low pin still forced");
    property p_level_held;
        strapsTaken |=> $stable(levelSel) && strapsTaken;
    endproperty
    a_level_held: assert property (p_level_held) else $error("level changed");
    property p_freq_held;
        strapsTaken |=> $stable(freqSel);
    endproperty
    a_freq_held: assert property (p_freq_held) else $error("frequency changed");
    property p_float_no_switch;
        (strapsTaken && freqSel == FQ_NONE) |=> !status.switchEn;
    endproperty
    a_float_no_switch: assert property (p_float_no_switch) else $error("switching on float");
    property p_divider_off;
        status.level == LV_EXT_DIV |-> !status.internalDividerOn;
    endproperty
    a_divider_off: assert property (p_divider_off) else $error("divider on");
    property p_release_delay;
        $rose(flagHigh) |-> releaseCnt == CNT_W'(RISE_DELAY) && $past(state) == PS_RUN;
    endproperty
    a_release_delay: assert property (p_release_delay) else $error("early release");
    property p_fault_pulls;
        faultNow |=> tripped ##1 resetFlagOe;
    endproperty
    a_fault_pulls: assert property (p_fault_pulls) else $error("fault not flagged");
endmodule : bsms_sequencer
`default_nettype wire

/* tb/bsms_board_model.sv */
// Board side of the reset flag: pull-up resistor read by the system processor.
// Assumes the sequencer drives the flag open-drain through an output enable.
`timescale 1ns/1ps
`default_nettype none
module bsms_board_model (
    // Device pad
    input wire logic flagOe,
    input wire logic flagOut,
    // Level seen by the processor
    output logic flagWire
);
    // Pull-up wins whenever the device lets the pin go
    assign flagWire = flagOe ? flagOut : 1'b1;
endmodule : bsms_board_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the buck start-up and mode sequencer.
// Assumes shortened timer parameters; the strap pins act as board straps.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bsms_pkg::*;
    localparam int SD = 20;
    localparam int RT = 30;
    localparam int RD = 40;
    localparam int DG = 5;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    bsmsEnable_s enable = '0;
    bsmsStraps_s straps = '0;
    logic modePin = 1'b0;
    logic spreadFitted = 1'b0;
    logic loadLight = 1'b0;
    logic fbInRegulation = 1'b1;
    logic currentLimit = 1'b0;
    logic thermalShutdown = 1'b0;
    logic resetFlagOut;
    logic resetFlagOe;
    logic flagWire;
    bsmsStatus_s status;
    int badCount = 0;
    int samplesChecked = 0;

    // Clock at 250 MHz
    always #2 clock = ~clock;

    bsms_sequencer #(.START_DELAY(SD), .RAMP_TIME(RT), .RISE_DELAY(RD), .DEGLITCH(DG),
        .SPREAD_STEP(8)) DUT (.clock(clock), .rst_n(rst_n), .ce(ce), .enable(enable),
        .straps(straps), .modePin(modePin), .spreadFitted(spreadFitted),
        .loadLight(loadLight), .fbInRegulation(fbInRegulation), .currentLimit(currentLimit),
        .thermalShutdown(thermalShutdown), .resetFlagIn(flagWire),
        .resetFlagOut(resetFlagOut), .resetFlagOe(resetFlagOe), .status(status));

    bsms_board_model board (.flagOe(resetFlagOe), .flagOut(resetFlagOut), .flagWire(flagWire));

    task automatic end_of_test();
        if (badCount == 0 && samplesChecked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            badCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Sampling right after the edge sees values settled in the cycle before
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask : step

    // Bounded wait, so a stuck state shows up as a wrong count
    task automatic waitState(input bsmsPower_e s, input int maxc, output int n);
        n = 0;
        while (status.state !== s && n < maxc) begin
            step(1);
            n++;
        end
    endtask : waitState

    task automatic waitFlag(output int n);
        n = 0;
        while (flagWire !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
    endtask : waitFlag

    task automatic inWindow(input int n, input int lo, input int hi);
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask : inWindow

    // Power-on cycle, then standby, then enable up to the start delay
    task automatic powerUp(input bsmsStraps_s s);
        int n;
        enable <= '0;
        straps <= s;
        rst_n <= 1'b0;
        step(2);
        rst_n <= 1'b1;
        step(3);
        chk(32'(resetFlagOe), 32'h1);
        chk(32'(status.state), 32'(PS_OFF));
        enable <= 3'b100;
        waitState(PS_STANDBY, 10, n);
        chk(32'(status.vccOn), 32'h1);
        chk(32'(status.switchEn), 32'h0);
        enable <= 3'b111;
        waitState(PS_DELAY, 10, n);
        chk(32'(flagWire), 32'h0);
    endtask : powerUp

    initial begin
        bsmsStraps_s s;
        int n;
        bit seen;
        int rtTab [3];
        int khzTab [3];
        rtTab = '{20, 5, 70};
        khzTab = '{788, 2200, 250};
        s = '0;
        s.levelHigh = 1'b1;
        s.freqLow = 1'b1;
        powerUp(s);
        chk(32'(status.level), 32'(LV_5V));
        chk(32'(status.internalDividerOn), 32'h1);
        chk(32'(status.freq), 32'(FQ_2100K));
        chk(32'(status.freqKhz), 32'd2100);
        modePin <= 1'b1;
        waitState(PS_RAMP, SD + 10, n);
        inWindow(n, SD - 1, SD + 1);
        chk(32'(status.forcedFixed), 32'h0);
        step(RT / 2);
        chk(32'(status.forcedFixed), 32'h0);
        inWindow(int'(status.refCode), int'(REF_FULL) / 3, int'(REF_FULL) * 2 / 3);
        waitState(PS_RUN, RT + 10, n);
        inWindow(n, RT / 2 - 1, RT / 2 + 1);
        step(2);
        chk(32'(status.refCode), 32'(REF_FULL));
        chk(32'(status.forcedFixed), 32'h1);
        chk(32'(flagWire), 32'h0);
        waitFlag(n);
        inWindow(n, RD - 5, RD);
        // In-range sync clock on the mode pin, half period 57 cycles
        repeat (4) begin
            modePin <= ~modePin;
            step(5);
            chk(32'(status.syncLocked), 32'h1);
            chk(32'(status.forcedFixed), 32'h1);
            step(52);
        end
        // Mode pin changes while running, adaptive mode follows the load
        modePin <= 1'b0;
        loadLight <= 1'b1;
        step(30);
        chk(32'(status.forcedFixed), 32'h0);
        chk(32'(status.pulseSkip), 32'h1);
        loadLight <= 1'b0;
        step(3);
        chk(32'(status.pulseSkip), 32'h0);
        // Short dip must be filtered, long dip must trip
        fbInRegulation <= 1'b0;
        step(DG - 2);
        fbInRegulation <= 1'b1;
        step(5);
        chk(32'(flagWire), 32'h1);
        fbInRegulation <= 1'b0;
        step(DG + 4);
        chk(32'(flagWire), 32'h0);
        fbInRegulation <= 1'b1;
        waitFlag(n);
        inWindow(n, RD - 1, RD + 4);
        // Both fault kinds pull the flag at once
        for (int i = 0; i < 2; i++) begin
            currentLimit <= (i == 0);
            thermalShutdown <= (i == 1);
            step(3);
            chk(32'(flagWire), 32'h0);
            currentLimit <= 1'b0;
            thermalShutdown <= 1'b0;
            waitFlag(n);
            inWindow(n, RD - 1, RD + 4);
        end
        // Dither stays within three percent and actually moves
        spreadFitted <= 1'b1;
        seen = 0;
        repeat (40) begin
            step(1);
            chk(32'(status.ditherTenthPct >= -30 && status.ditherTenthPct <= 30), 32'h1);
            if (status.ditherTenthPct !== 8'h00) seen = 1;
        end
        chk(32'(seen), 32'h1);
        // Enable cycling keeps the captured straps
        straps <= 13'h0c00;
        enable <= 3'b100;
        waitState(PS_STANDBY, 10, n);
        step(2);
        chk(32'(flagWire), 32'h0);
        chk(32'(status.switchEn), 32'h0);
        enable <= 3'b111;
        waitState(PS_DELAY, 10, n);
        chk(32'(status.level), 32'(LV_5V));
        chk(32'(status.freq), 32'(FQ_2100K));
        // Clock enable low freezes the sequencer despite enable dropping
        ce <= 1'b0;
        enable <= 3'b000;
        step(5);
        chk(32'(status.state), 32'(PS_DELAY));
        ce <= 1'b1;
        waitState(PS_OFF, 10, n);
        step(2);
        chk(32'(status.vccOn), 32'h0);
        // Resistor-set frequency, including both clamp ends
        for (int i = 0; i < 3; i++) begin
            s = '0;
            s.rtKohm = 8'(rtTab[i]);
            powerUp(s);
            chk(32'(status.level), 32'(LV_EXT_DIV));
            chk(32'(status.internalDividerOn), 32'h0);
            chk(32'(status.freq), 32'(FQ_ADJ));
            chk(32'(status.freqKhz), 32'(khzTab[i]));
        end
        // Steady-high frequency strap with the low level strap
        s = '0;
        s.levelLow = 1'b1;
        s.freqHigh = 1'b1;
        powerUp(s);
        chk(32'(status.level), 32'(LV_3V3));
        chk(32'(status.freq), 32'(FQ_400K));
        chk(32'(status.freqKhz), 32'h190);
        // Floating frequency strap: no switching even in run
        s = '0;
        s.freqFloat = 1'b1;
        powerUp(s);
        waitState(PS_RUN, SD + RT + 10, n);
        step(2);
        chk(32'(status.freq), 32'(FQ_NONE));
        chk(32'(status.switchEn), 32'h0);
        end_of_test();
    end

    // Whole run is well under a thousand cycles; this only catches a hang
    initial begin
        #200000;
        badCount++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
